// File: shared/tcdd_consts.svh
// What this block does
// - arming fetches the channel's eight-byte descriptor
// - each channel has its own descriptor pointer
// - abort disarms every channel written as one
// - aborted transfer sets no flag, no interrupt
// - completion sets flag whatever the mask
// - descriptor mask bit gates the interrupt
// - big-endian source and destination addresses
// - length mode picks fixed or first-item counts
// - word mode length uses bits 12:0
// - thirteen-bit count, also the variable maximum
// - count words in word mode, else bytes
// - size bit picks byte or word transfers
// - mode field picks single, block or repeated
// - five-bit field picks one of 32 triggers
// - code 0 software only, code 1 previous
// - codes 2 to 11 are timer/radio events
// - codes 14,15,18,19,29-31 are peripheral events
// - codes 12,13,16,20-28 are variant events
// - source and destination step after each transfer
// - seven-bit length option for byte mode
// - low, assured and high priority against cpu
// - single per trigger, block whole count; rearm
// - arming copies addresses; unit is byte/word
// - software request clears only on transfer
// - equal priorities resolved round-robin
`ifndef TCDD_CONSTS_SVH
`define TCDD_CONSTS_SVH
`define TCDD_OFS_ARM 8'h00
`define TCDD_OFS_REQ 8'h04
`define TCDD_OFS_PTR0 8'h08
`define TCDD_OFS_PTR1 8'h0c
`define TCDD_OFS_FLAG 8'h10
`define TCDD_OFS_STAT 8'h14
`define TCDD_ABORT_BIT 7
`define TCDD_DESC_LAST 3'h7
`define TCDD_PRIO_LOW 2'h0
`define TCDD_PRIO_ASSURED 2'h1
`define TCDD_PRIO_HIGH 2'h2
`define TCDD_LENGTH_MODE_FIELD_P1 3'h1
`define TCDD_LENGTH_MODE_FIELD_P0 3'h2
`define TCDD_LENGTH_MODE_FIELD_P2 3'h3
`define TCDD_LENGTH_MODE_FIELD_P3 3'h4
`define TCDD_STEP_NONE 2'h0
`define TCDD_STEP_ONE 2'h1
`define TCDD_STEP_TWO 2'h2
`define TCDD_TRIGGER_SELECT_FIELD_NONE 5'h00
`define TCDD_TRIGGER_SELECT_FIELD_PREV 5'h01
`endif

// File: shared/tcdd_pkg.sv
/*
 types of the two-channel descriptor dma.
 assumes tcdd_consts.svh for all numeric constants.
*/
package tcdd_pkg;
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_FETCH = 2'h1,
      S_RD = 2'h3,
      S_WR = 2'h2
   } tcdd_state_t;

   // byte 0 sits in the top bits, so shifting bytes in fills it
   typedef struct packed {
      logic [15:0] src;
      logic [15:0] dst;
      logic [2:0] length_mode_field;
      logic [12:0] len;
      logic word;
      logic [1:0] transfer_mode_field;
      logic [4:0] trigger_select_field;
      logic [1:0] sinc;
      logic [1:0] dinc;
      logic irqm;
      logic m8;
      logic [1:0] prio;
   } tcdd_desc_t;

   typedef struct packed {
      logic armed;
      logic fetch;
      logic pend;
      logic swreq;
      logic blk;
      logic flag;
      logic skip;
      logic [15:0] ptr;
      tcdd_desc_t d;
      logic [15:0] src_p;
      logic [15:0] dst_p;
      logic [12:0] cnt;
      logic [12:0] lim;
   } tcdd_chan_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } tcdd_mreq_t;

   typedef struct packed {
      tcdd_chan_t [1:0] ch;
      tcdd_state_t st;
      logic cur;
      logic rr;
      logic [2:0] bc;
      logic [15:0] dat;
      logic [1:0] done;
      logic asel;
      logic awr;
      logic [7:0] aad;
      logic [31:0] hrdata;
      logic hready;
      logic resp;
      tcdd_mreq_t m;
      logic irq;
   } tcdd_st_t;
endpackage : tcdd_pkg

// File: src/tcdd_top.sv
/*
 two-channel descriptor dma: ahb-lite register slave, descriptor
 fetch, byte/word mover and cpu arbitration on one byte memory port.
 assumes a memory that answers each held request with a one-cycle
 mem_ack (read data with it) and drops a withdrawn request quietly.
*/
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`include "tcdd_consts.svh"
module tcdd_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output tcdd_pkg::tcdd_mreq_t mem,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic cpu_req,
   input wire logic [31:0] trigger_select_field_in,
   output logic irq
);
   import tcdd_pkg::*;

   tcdd_st_t q, d;
   logic [1:0] abt, cmp, start, fd;
   logic [1:0] curp;

   function automatic logic [31:0] rd_mux(input tcdd_st_t s,
                                          input logic [7:0] a);
      logic [31:0] r;
      r = '0;
      case (a)
         `TCDD_OFS_ARM: r[1:0] = {s.ch[1].armed, s.ch[0].armed};
         `TCDD_OFS_REQ: r[1:0] = {s.ch[1].swreq, s.ch[0].swreq};
         `TCDD_OFS_PTR0: r[15:0] = s.ch[0].ptr;
         `TCDD_OFS_PTR1: r[15:0] = s.ch[1].ptr;
         `TCDD_OFS_FLAG: r[1:0] = {s.ch[1].flag, s.ch[0].flag};
         `TCDD_OFS_STAT: r[3:0] = {s.st, s.cur, s.st != S_IDLE};
         default: r = '0;
      endcase
      return r;
   endfunction : rd_mux

   // reserved code 11 ranks as low
   function automatic logic [1:0] rank(input logic [1:0] p);
      return (p == 2'h3) ? 2'h0 : p;
   endfunction : rank

   function automatic logic may_go(input logic [1:0] p,
                                   input logic cpu,
                                   input logic skip);
      logic g;
      g = !cpu;
      if (p == `TCDD_PRIO_HIGH) begin
         g = 1'b1;
      end else if (p == `TCDD_PRIO_ASSURED) begin
         g = !cpu || skip;
      end
      return g;
   endfunction : may_go

   // one unit is a byte, or two bytes in word mode
   function automatic logic [15:0] step(input logic [1:0] s,
                                        input logic w);
      logic [15:0] u;
      u = w ? 16'h0002 : 16'h0001;
      case (s)
         `TCDD_STEP_NONE: step = 16'h0000;
         `TCDD_STEP_ONE: step = u;
         `TCDD_STEP_TWO: step = {u[14:0], 1'b0};
         default: step = 16'h0000 - u;
      endcase
   endfunction : step

   function automatic logic hit(input logic [4:0] code,
                                input logic [31:0] t,
                                input logic prev);
      logic h;
      h = t[code];
      if (code == `TCDD_TRIGGER_SELECT_FIELD_NONE) begin
         h = 1'b0;
      end else if (code == `TCDD_TRIGGER_SELECT_FIELD_PREV) begin
         h = prev;
      end
      return h;
   endfunction : hit

   assign curp = q.ch[q.cur].d.prio;

   always_comb begin
      tcdd_chan_t c;
      tcdd_desc_t nd;
      logic [1:0] want;
      logic sel;
      logic last;
      logic [13:0] vl, tgt, cn;
      logic [12:0] le;
      logic vr;
      c = '0;
      nd = '0;
      want = '0;
      sel = 1'b0;
      last = 1'b0;
      vl = '0;
      tgt = '0;
      cn = '0;
      le = '0;
      vr = 1'b0;
      d = q;
      d.done = '0;
      d.hready = 1'b1;
      d.resp = 1'b0;
      abt = '0;
      cmp = '0;
      start = '0;
      fd = '0;

      // ahb address phase; read data is staged for the data phase
      if (hready) begin
         d.asel = hsel && htrans[1];
         d.awr = hwrite;
         d.aad = haddr[7:0];
         if (hsel && htrans[1] && !hwrite) begin
            d.hrdata = rd_mux(q, haddr[7:0]);
         end
      end

      // ahb data phase write
      if (q.asel && q.awr) begin
         for (int i = 0; i < 2; i++) begin
            case (q.aad)
               `TCDD_OFS_ARM: begin
                  if (hwdata[i] && hwdata[`TCDD_ABORT_BIT]) begin
                     abt[i] = 1'b1;
                  end else if (hwdata[i] && !q.ch[i].armed) begin
                     d.ch[i].armed = 1'b1;
                     d.ch[i].fetch = 1'b1;
                  end
               end
               `TCDD_OFS_REQ: begin
                  if (hwdata[i]) begin
                     d.ch[i].swreq = 1'b1;
                  end
               end
               `TCDD_OFS_FLAG: begin
                  if (!hwdata[i]) begin
                     d.ch[i].flag = 1'b0;
                  end
               end
               default: ;
            endcase
         end
         if (q.aad == `TCDD_OFS_PTR0) begin
            d.ch[0].ptr = hwdata[15:0];
         end
         if (q.aad == `TCDD_OFS_PTR1) begin
            d.ch[1].ptr = hwdata[15:0];
         end
      end

      // hardware triggers are latched while armed and no descriptor fetch is pending
      for (int i = 0; i < 2; i++) begin
         if (q.ch[i].armed && !q.ch[i].fetch &&
             hit(q.ch[i].d.trigger_select_field, trigger_select_field_in, q.done[1 - i])) begin
            d.ch[i].pend = 1'b1;
         end
      end

      unique case (q.st)
         S_IDLE: begin
            for (int i = 0; i < 2; i++) begin
               want[i] = q.ch[i].armed && !abt[i] &&
                  (q.ch[i].fetch || q.ch[i].blk ||
                   q.ch[i].pend || q.ch[i].swreq);
            end
            sel = want[1];
            if (&want) begin
               if (rank(q.ch[0].d.prio) == rank(q.ch[1].d.prio)) begin
                  sel = q.rr;
               end else begin
                  sel = rank(q.ch[1].d.prio) > rank(q.ch[0].d.prio);
               end
            end
            if (|want) begin
               d.cur = sel;
               d.rr = !sel;
               d.bc = '0;
               if (q.ch[sel].fetch) begin
                  d.st = S_FETCH;
               end else begin
                  d.st = S_RD;
                  start[sel] = 1'b1;
                  if (!q.ch[sel].blk) begin
                     // one trigger is used up per start
                     if (q.ch[sel].pend) begin
                        d.ch[sel].pend = 1'b0;
                     end else begin
                        d.ch[sel].swreq = 1'b0;
                     end
                     d.ch[sel].blk = q.ch[sel].d.transfer_mode_field[0];
                  end
               end
            end
         end
         S_FETCH, S_RD, S_WR: begin
            c = q.ch[q.cur];
            if (!q.m.req) begin
               if (may_go(c.d.prio, cpu_req, c.skip)) begin
                  d.m.req = 1'b1;
                  d.m.we = q.st == S_WR;
                  d.ch[q.cur].skip = 1'b0;
                  d.m.wdata = q.bc[0] ? q.dat[15:8] : q.dat[7:0];
                  unique case (q.st)
                     S_FETCH: d.m.addr = c.ptr + {13'h0, q.bc};
                     S_RD: d.m.addr = c.src_p + {13'h0, q.bc};
                     default: d.m.addr = c.dst_p + {13'h0, q.bc};
                  endcase
               end else if (c.d.prio == `TCDD_PRIO_ASSURED) begin
                  d.ch[q.cur].skip = 1'b1;
               end
            end else if (mem_ack) begin
               d.m.req = 1'b0;
               last = q.bc == {2'h0, c.d.word};
               d.bc = q.bc + 3'h1;
               unique case (q.st)
                  S_FETCH: begin
                     nd = {c.d[55:0], mem_rdata};
                     d.ch[q.cur].d = nd;
                     if (q.bc == `TCDD_DESC_LAST) begin
                        d.st = S_IDLE;
                        fd[q.cur] = 1'b1;
                        d.ch[q.cur].fetch = 1'b0;
                        d.ch[q.cur].src_p = nd.src;
                        d.ch[q.cur].dst_p = nd.dst;
                        d.ch[q.cur].cnt = '0;
                        d.ch[q.cur].lim = nd.len;
                     end
                  end
                  S_RD: begin
                     d.dat = q.bc[0] ? {mem_rdata, q.dat[7:0]} :
                        {8'h00, mem_rdata};
                     if (last) begin
                        d.st = S_WR;
                        d.bc = '0;
                     end
                  end
                  default: begin
                     if (last) begin
                        d.st = S_IDLE;
                        if (c.d.word) begin
                           vl = {1'b0, q.dat[12:0]};
                        end else if (c.d.m8) begin
                           vl = {7'h00, q.dat[6:0]};
                        end else begin
                           vl = {6'h00, q.dat[7:0]};
                        end
                        vr = 1'b1;
                        case (c.d.length_mode_field)
                           `TCDD_LENGTH_MODE_FIELD_P1: tgt = vl + 14'h1;
                           `TCDD_LENGTH_MODE_FIELD_P0: tgt = vl;
                           `TCDD_LENGTH_MODE_FIELD_P2: tgt = vl + 14'h2;
                           `TCDD_LENGTH_MODE_FIELD_P3: tgt = vl + 14'h3;
                           default: vr = 1'b0;
                        endcase
                        le = c.lim;
                        if (vr && c.cnt == 13'h0) begin
                           le = (tgt > {1'b0, c.d.len}) ? c.d.len :
                              tgt[12:0];
                        end
                        cn = {1'b0, c.cnt} + 14'h1;
                        d.ch[q.cur].src_p =
                           c.src_p + step(c.d.sinc, c.d.word);
                        d.ch[q.cur].dst_p =
                           c.dst_p + step(c.d.dinc, c.d.word);
                        d.ch[q.cur].cnt = cn[12:0];
                        d.ch[q.cur].lim = le;
                        if (cn >= {1'b0, le}) begin
                           cmp[q.cur] = 1'b1;
                           d.done[q.cur] = 1'b1;
                           d.ch[q.cur].flag = 1'b1;
                           d.ch[q.cur].blk = 1'b0;
                           d.ch[q.cur].cnt = '0;
                           if (c.d.transfer_mode_field[1]) begin
                              // repeated modes rearm from the descriptor
                              d.ch[q.cur].src_p = c.d.src;
                              d.ch[q.cur].dst_p = c.d.dst;
                              d.ch[q.cur].lim = c.d.len;
                           end else begin
                              d.ch[q.cur].armed = 1'b0;
                           end
                        end
                     end
                  end
               endcase
            end
         end
      endcase

      // abort wins over a completion in the same cycle
      for (int i = 0; i < 2; i++) begin
         if (abt[i]) begin
            d.ch[i].armed = 1'b0;
            d.ch[i].fetch = 1'b0;
            d.ch[i].pend = 1'b0;
            d.ch[i].blk = 1'b0;
            d.ch[i].flag = q.ch[i].flag && d.ch[i].flag;
            d.done[i] = 1'b0;
            if (q.st != S_IDLE && q.cur == i[0]) begin
               d.st = S_IDLE;
               d.m.req = 1'b0;
            end
         end
      end

      // stale flags still interrupt when the mask is set
      d.irq = (d.ch[0].flag && d.ch[0].d.irqm) ||
         (d.ch[1].flag && d.ch[1].d.irqm);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign hreadyout = q.hready;
   assign hresp = q.resp;
   assign hrdata = q.hrdata;
   assign mem = q.m;
   assign irq = q.irq;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_ABORT_DISARM: assert property (
      abt[0] |=> !q.ch[0].armed && !q.ch[0].pend)
      else $error("aborted channel 0 still armed");
   AST_ABORT_NO_FLAG: assert property (
      abt[0] && !q.ch[0].flag && !q.ch[1].flag && !cmp[1]
      |=> !q.ch[0].flag && !irq)
      else $error("aborted channel 0 set its flag");
   AST_DONE_FLAG: assert property (
      cmp[0] && !abt[0] |=> q.ch[0].flag)
      else $error("completion did not set flag");
   AST_DONE_IRQ: assert property (
      cmp[1] && !abt[1] && q.ch[1].d.irqm |=> irq)
      else $error("unmasked completion gave no interrupt");
   AST_SWREQ_KEEP: assert property (
      q.ch[0].swreq && !start[0] |=> q.ch[0].swreq)
      else $error("software request lost without a transfer");
   AST_PTR_LOAD: assert property (
      fd[0] && !abt[0] |=> q.ch[0].src_p == q.ch[0].d.src
         && q.ch[0].dst_p == q.ch[0].d.dst && q.ch[0].cnt == 13'h0)
      else $error("pointers not loaded after fetch");
   AST_HIGH_GOES: assert property (
      q.st != S_IDLE && !q.m.req && curp == `TCDD_PRIO_HIGH && abt == 2'h0
      |=> q.m.req)
      else $error("high priority channel deferred");
   AST_LOW_DEFERS: assert property (
      q.st != S_IDLE && !q.m.req && curp == `TCDD_PRIO_LOW && cpu_req
      |=> !q.m.req)
      else $error("low priority channel beat the cpu");
   AST_SINGLE_DISARM: assert property (
      cmp[1] && !q.ch[1].d.transfer_mode_field[1] |=> !q.ch[1].armed ##1 !q.ch[1].blk)
      else $error("non-repeated channel still armed");
   AST_FETCH_EIGHT: assert property (
      $rose(q.st == S_FETCH) |-> !fd[q.cur] [*8])
      else $error("descriptor fetch shorter than eight bytes");
endmodule : tcdd_top

// File: tb/tcdd_mem_model.sv
/*
 byte memory standing on the far side of the dma memory port.
 assumes the port holds a request until the edge that sees mem_ack.
*/
module tcdd_mem_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire tcdd_pkg::tcdd_mreq_t mem,
   input wire logic [3:0] lat,
   output logic mem_ack = 1'b0,
   output logic [7:0] mem_rdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   import tcdd_pkg::*;
   logic [7:0] store [0:65535];
   int wt;
   // a withdrawn request restarts the wait, as an abort may drop it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'b0;
         wt = 0;
      end else begin
         mem_ack <= 1'b0;
         // stale read data flips every cycle so it never looks valid
         mem_rdata <= ~mem_rdata;
         if (mem.req && !mem_ack) begin
            if (wt >= int'(lat)) begin
               mem_ack <= 1'b1;
               wt = 0;
               if (mem.we) store[mem.addr] = mem.wdata;
               else mem_rdata <= store[mem.addr];
            end else begin
               wt++;
            end
         end else begin
            wt = 0;
         end
      end
   end
endmodule : tcdd_mem_model

// File: tb/tcdd_tb.sv
/*
 self-checking bench of the two-channel descriptor dma.
 assumes tcdd_top, tcdd_pkg and the byte memory partner model.
*/
`define TCDD_CHK(g, e) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
   end \
end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tcdd_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic cpu_req = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [1:0] cmode = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] trigger_select_field_in = 32'h0;
   logic [31:0] rs = 32'h5c9a;
   logic [31:0] rc, cq, rd, hrdata;
   logic [3:0] lat = 4'h0;
   logic [7:0] em [0:65535];
   logic [7:0] mem_rdata;
   logic hreadyout, hresp, irq, mem_ack;
   tcdd_mreq_t mem;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   tcdd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .cpu_req(cpu_req), .trigger_select_field_in(trigger_select_field_in),
      .irq(irq));
   tcdd_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem(mem),
      .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      forever #50 hclk = ~hclk;
   end

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // random cpu contention unless a scenario holds it at a level
   always @(posedge hclk) begin
      cyc++;
      cq = rnd();
      cpu_req <= cmode[1] ? cmode[0] : cq[0];
      if (cyc == 80000) begin
         $display("[FAIL] %0t run timed out", $time);
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `TCDD_CHK(hresp, 1'b0)
   endtask : ahb

   task automatic settle();
      repeat (3) @(posedge hclk);
      do ahb(1'b0, 8'h14, 32'h0); while (rd[0] !== 1'b0);
   endtask : settle

   task automatic put(input logic [15:0] a, input logic [7:0] v);
      mem_u.store[a] = v;
      em[a] = v;
   endtask : put

   function automatic int stp(input logic [1:0] m, input int u);
      case (m)
         2'h0: return 0;
         2'h1: return u;
         2'h2: return 2 * u;
         default: return -u;
      endcase
   endfunction : stp

   task automatic fire(input bit ch, input logic [4:0] tg);
      if (tg == 5'h00) begin
         ahb(1'b1, 8'h04, 32'h1 << ch);
      end else begin
         @(posedge hclk);
         trigger_select_field_in[tg] <= 1'b1;
         @(posedge hclk);
         trigger_select_field_in <= 32'h0;
      end
   endtask : fire

   task automatic load(input bit ch, input tcdd_desc_t d);
      int k;
      logic [15:0] p;
      p = ch ? 16'h0340 : 16'h0200;
      for (k = 0; k < 8; k++) begin
         put(p + 16'(k), d[63 - 8 * k -: 8]);
      end
      ahb(1'b1, ch ? 8'h0c : 8'h08, {16'h0, p});
      ahb(1'b1, 8'h00, 32'h1 << ch);
      settle();
   endtask : load

   task automatic run(input bit ch, input tcdd_desc_t d);
      int n, u, f, k, ntr;
      logic [15:0] s, t;
      load(ch, d);
      u = d.word ? 2 : 1;
      f = d.word ? {em[d.src + 16'h1], em[d.src]} & 16'h1fff
         : em[d.src] & (d.m8 ? 8'h7f : 8'hff);
      case (d.length_mode_field)
         3'h1: n = f + 1;
         3'h2: n = f;
         3'h3: n = f + 2;
         3'h4: n = f + 3;
         default: n = d.len;
      endcase
      if (d.length_mode_field inside {[3'h1:3'h4]} && n > d.len) n = d.len;
      s = d.src;
      t = d.dst;
      for (k = 0; k < n; k++) begin
         em[t] = em[s];
         if (u == 2) em[t + 16'h1] = em[s + 16'h1];
         s = s + 16'(stp(d.sinc, u));
         t = t + 16'(stp(d.dinc, u));
      end
      ntr = 0;
      k = 0;
      // block modes get one trigger only, then just wait for the flag
      do begin
         if (ntr == 0 || !d.transfer_mode_field[0]) begin
            fire(ch, d.trigger_select_field);
            ntr++;
         end
         settle();
         ahb(1'b0, 8'h10, 32'h0);
         k++;
      end while (rd[ch] !== 1'b1 && k < 40);
      `TCDD_CHK(rd[ch], 1'b1)
      `TCDD_CHK(ntr, d.transfer_mode_field[0] ? 1 : n)
      for (k = 16'h1000; k < 16'h1100; k++) begin
         `TCDD_CHK(mem_u.store[k], em[k])
      end
      @(posedge hclk);
      `TCDD_CHK(irq, d.irqm)
      ahb(1'b0, 8'h00, 32'h0);
      `TCDD_CHK(rd[ch], d.transfer_mode_field[1])
      ahb(1'b0, 8'h04, 32'h0);
      `TCDD_CHK(rd[ch], 1'b0)
      ahb(1'b1, 8'h10, ~(32'h1 << ch));
      if (d.transfer_mode_field[1]) ahb(1'b1, 8'h00, 32'h80 | (32'h1 << ch));
      ahb(1'b0, 8'h10, 32'h0);
      `TCDD_CHK(rd[1:0], 2'h0)
   endtask : run

   initial begin
      tcdd_desc_t d;
      int k;
      for (k = 0; k < 65536; k++) begin
         rc = rnd();
         put(16'(k), rc[7:0]);
      end
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (k = 0; k < 9; k++) begin
         ahb(1'b0, 8'(4 * k), 32'h0);
         `TCDD_CHK(rd, 32'h0)
      end
      // code 1 needs the other channel running, so it is left out here
      for (k = 0; k < 32; k++) begin
         if (k != 1) begin
            rc = rnd();
            d.src = 16'h1000 + 16'(rc[3:0]);
            d.dst = 16'h10a0;
            d.length_mode_field = (rc[6:4] inside {3'h5, 3'h6}) ? 3'h7 : rc[6:4];
            d.len = 13'(rc[9:7]) + 13'h1;
            d.word = rc[10];
            d.transfer_mode_field = rc[12:11];
            d.trigger_select_field = 5'(k);
            d.sinc = rc[14:13];
            d.dinc = rc[16:15];
            d.irqm = rc[17];
            d.m8 = rc[18];
            d.prio = (rc[20:19] == 2'h3) ? 2'h2 : rc[20:19];
            lat <= {1'b0, rc[23:21]};
            put(d.src, {rc[24], 4'h0, rc[26:25], 1'b1});
            put(d.src + 16'h1, {rc[29:27], 5'h0});
            run(k[0], d);
         end
      end
      d = '0;
      d.src = 16'h1000;
      d.dst = 16'h1080;
      d.len = 13'h8;
      d.transfer_mode_field = 2'h1;
      d.sinc = 2'h1;
      d.dinc = 2'h1;
      d.irqm = 1'b1;
      d.prio = 2'h2;
      load(1'b0, d);
      lat <= 4'hf;
      fire(1'b0, 5'h00);
      repeat (20) @(posedge hclk);
      ahb(1'b1, 8'h00, 32'h81);
      repeat (60) @(posedge hclk);
      ahb(1'b0, 8'h00, 32'h0);
      `TCDD_CHK(rd[1:0], 2'h0)
      ahb(1'b0, 8'h10, 32'h0);
      `TCDD_CHK(rd[1:0], 2'h0)
      `TCDD_CHK(irq, 1'b0)
      d.irqm = 1'b0;
      d.len = 13'h2;
      for (k = 0; k < 3; k++) begin
         d.prio = 2'(k);
         lat <= 4'h0;
         cmode <= 2'h0;
         load(1'b1, d);
         cmode <= 2'h3;
         fire(1'b1, 5'h00);
         repeat (60) @(posedge hclk);
         ahb(1'b0, 8'h10, 32'h0);
         `TCDD_CHK(rd[1], k != 0)
         cmode <= 2'h2;
         do ahb(1'b0, 8'h10, 32'h0); while (rd[1] !== 1'b1);
         ahb(1'b1, 8'h10, 32'h0);
      end
      // channel 1 waits on code 1 and follows channel 0's completion
      d.trigger_select_field = 5'h01;
      d.dst = 16'h10e0;
      load(1'b1, d);
      d.trigger_select_field = 5'h00;
      d.dst = 16'h10d0;
      load(1'b0, d);
      fire(1'b0, 5'h00);
      repeat (80) @(posedge hclk);
      ahb(1'b0, 8'h10, 32'h0);
      `TCDD_CHK(rd[1:0], 2'h3)
      for (k = 0; k < 2; k++) begin
         `TCDD_CHK(mem_u.store[16'h10e0 + k], em[16'h1000 + k])
      end
      give_verdict();
   end
endmodule : testbench
